// ==== design/tcbd_core.v ====
// Channel 3/4 compare values, break and dead-time control, DMA burst window
// ------------------------------------------------------------------
// Summary of operation
// - Output channel compares value against counter
// - Preload off writes direct, else on update
// - Input mode latches capture, register read-only
// - Main enable set sw/hw, cleared by break
// - Main enable gates channel output enables
// - Auto enable sets main on update, no break
// - Break polarity chooses active level, delayed
// - Break enable gates pin and clock failure
// - Run off-state drives inactive outputs enabled
// - Idle off-state drives idle outputs enabled unless break active
// - Lock level zero leaves everything writable
// - Level one locks dead-time, break, idle bits
// - Level two also locks polarity, off-state
// - Level three also locks compare mode, preload
// - Lock field writable once after reset
// - Dead time decoded from eight-bit code
// - Burst count is field plus one
// - Base index picks first burst register
// - Window access redirected to base plus offset
// - Event issues DMA requests until burst done
// ------------------------------------------------------------------
`include "tcbd_defines.vh"

module tcbd_core (
  input  wire        core_clk_in,
  input  wire        nrst_in,
  // Register port: byte address, one-cycle strobes
  input  wire [6:0]  reg_addr_in,
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  input  wire [15:0] reg_wdata_in,
  output reg  [15:0] reg_rdata_out,
  // Redirected access toward the rest of the timer register map
  output reg  [6:0]  fwd_addr_out,
  output reg         fwd_wr_out,
  output reg         fwd_rd_out,
  output reg  [15:0] fwd_wdata_out,
  input  wire [15:0] fwd_rdata_in,
  // Time base and events from the timer core
  input  wire [15:0] counter_in,
  input  wire        update_evt_in,
  input  wire        dma_evt_in,
  input  wire        dma_ack_in,
  output reg         dma_req_out,
  // Channel 3/4 configuration (index 0 = channel 3)
  input  wire [1:0]  chan_is_input_in,
  input  wire [1:0]  capture_evt_in,
  input  wire [1:0]  chan_compare_preload_en_in,
  input  wire [1:0]  chan_output_on_in,
  input  wire [1:0]  chan_compl_output_on_in,
  // Break sources, from pins
  input  wire        break_pin_in,
  input  wire        clock_failure_detector_in,
  // Compare results and output enables per channel
  output reg  [1:0]  compare_match_out,
  output reg  [1:0]  chan_oe_out,
  output reg  [1:0]  chan_compl_oe_out,
  output reg         main_output_on_out,
  // Write-permission flags toward the other timer registers
  output reg         idle_level_wr_ok_out,
  output reg         polarity_wr_ok_out,
  output reg         compare_mode_wr_ok_out,
  // Dead time in dead-time ticks
  output reg  [10:0] dead_time_ticks_out
);

  // ------------------------------------------------------------------
  // Decode functions
  // ------------------------------------------------------------------
  // Dead-time code to tick count
  function [10:0] tcbd_dt_decode;
    input [7:0] code;
    begin
      if (!code[7]) begin
        tcbd_dt_decode = {3'h0, code};
      end else if (!code[6]) begin
        tcbd_dt_decode = (`TCBD_DT_BASE64 + {5'h00, code[5:0]}) << 1;
      end else if (!code[5]) begin
        tcbd_dt_decode = (`TCBD_DT_BASE32 + {6'h00, code[4:0]}) << 3;
      end else begin
        tcbd_dt_decode = (`TCBD_DT_BASE32 + {6'h00, code[4:0]}) << 4;
      end
    end
  endfunction

  // ------------------------------------------------------------------
  // Pin synchronisers and registers
  // ------------------------------------------------------------------
  reg  [1:0]  brk_pin_sync_r;
  reg  [1:0]  clk_fail_sync_r;
  reg  [15:0] cmp_pre_r [0:1];
  reg  [15:0] cmp_act_r [0:1];
  reg         moe_r;
  reg         aoe_r;
  reg         bkp_r;
  reg         break_input_on_r;
  reg         run_offstate_select_r;
  reg         idle_offstate_select_r;
  reg  [1:0]  lck_r;
  reg         lck_written_r;
  reg  [7:0]  dtg_r;
  reg         bkp_eff_r;
  reg         break_input_on_eff_r;
  reg  [4:0]  dbl_r;
  reg  [4:0]  dba_r;
  reg  [4:0]  burst_cnt_r;
  reg         fwd_pend_r;

  wire        brk_pin_s = brk_pin_sync_r[1];
  wire        clk_fail_s = clk_fail_sync_r[1];
  wire        wr_bkdt = reg_wr_in && (reg_addr_in == `TCBD_OFS_BKDT);
  wire        wr_dctrl = reg_wr_in && (reg_addr_in == `TCBD_OFS_DCTRL);
  wire        win_acc = (reg_wr_in || reg_rd_in) && (reg_addr_in == `TCBD_OFS_WINDOW);
  wire        brk_pol_ok = bkp_eff_r ? brk_pin_s : ~brk_pin_s;
  wire        brk_active = break_input_on_eff_r && (brk_pol_ok || clk_fail_s);
  wire        lck_ge1 = (lck_r != `TCBD_LCK_NONE);
  wire        lck_ge2 = (lck_r == `TCBD_LCK_L2) || (lck_r == `TCBD_LCK_L3);
  wire        lck_ge3 = (lck_r == `TCBD_LCK_L3);
  wire [6:0]  win_addr = `TCBD_OFS_CTRL1 + {dba_r + burst_cnt_r, 2'b00};
  wire        burst_last = (burst_cnt_r == dbl_r);

  // Break pin and clock failure synchronisers
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      brk_pin_sync_r  <= 2'h0;
      clk_fail_sync_r <= 2'h0;
    end else begin
      brk_pin_sync_r  <= {brk_pin_sync_r[0], break_pin_in};
      clk_fail_sync_r <= {clk_fail_sync_r[0], clock_failure_detector_in};
    end
  end

  // ------------------------------------------------------------------
  // Compare registers, channels 3 and 4
  // ------------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      wire [6:0] my_ofs = ch ? `TCBD_OFS_CMP4 : `TCBD_OFS_CMP3;
      // Direct and window writes both reach the compare value
      wire       my_wr = (reg_wr_in && reg_addr_in == my_ofs) ||
                         (win_acc && reg_wr_in && win_addr == my_ofs);
      always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          cmp_pre_r[ch] <= `TCBD_RST16;
          cmp_act_r[ch] <= `TCBD_RST16;
        end else if (chan_is_input_in[ch]) begin
          // Input mode: capture wins, writes are ignored
          if (capture_evt_in[ch]) begin
            cmp_pre_r[ch] <= counter_in;
            cmp_act_r[ch] <= counter_in;
          end
        end else begin
          if (my_wr) begin
            cmp_pre_r[ch] <= reg_wdata_in;
            if (!chan_compare_preload_en_in[ch]) begin
              cmp_act_r[ch] <= reg_wdata_in;
            end
          end
          // A write in the update cycle still lands one update later
          if (update_evt_in && chan_compare_preload_en_in[ch]) begin
            cmp_act_r[ch] <= cmp_pre_r[ch];
          end
        end
      end

      // Compare result and channel output enables
      always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          compare_match_out[ch] <= 1'b0;
          chan_oe_out[ch]       <= 1'b0;
          chan_compl_oe_out[ch] <= 1'b0;
        end else begin
          compare_match_out[ch] <= !chan_is_input_in[ch] &&
                                   (counter_in == cmp_act_r[ch]);
          if (chan_is_input_in[ch] || brk_active) begin
            chan_oe_out[ch]       <= 1'b0;
            chan_compl_oe_out[ch] <= 1'b0;
          end else if (moe_r) begin
            // Run mode: off-state enables when either side is on
            chan_oe_out[ch]       <= chan_output_on_in[ch] ||
                                     (run_offstate_select_r && chan_compl_output_on_in[ch]);
            chan_compl_oe_out[ch] <= chan_compl_output_on_in[ch] ||
                                     (run_offstate_select_r && chan_output_on_in[ch]);
          end else begin
            chan_oe_out[ch]       <= idle_offstate_select_r && (chan_output_on_in[ch] ||
                                     chan_compl_output_on_in[ch]);
            chan_compl_oe_out[ch] <= idle_offstate_select_r && (chan_output_on_in[ch] ||
                                     chan_compl_output_on_in[ch]);
          end
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // Break and dead-time control
  // ------------------------------------------------------------------
  wire bk_hit = wr_bkdt || (win_acc && reg_wr_in && win_addr == `TCBD_OFS_BKDT);

  // Protected fields obey the lock level in force before this write
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      moe_r         <= 1'b0;
      aoe_r         <= 1'b0;
      bkp_r         <= 1'b0;
      break_input_on_r        <= 1'b0;
      run_offstate_select_r        <= 1'b0;
      idle_offstate_select_r        <= 1'b0;
      lck_r         <= `TCBD_LCK_NONE;
      lck_written_r <= 1'b0;
      dtg_r         <= 8'h00;
    end else begin
      if (bk_hit) begin
        if (!lck_ge1) begin
          aoe_r  <= reg_wdata_in[`TCBD_BK_AOE];
          bkp_r  <= reg_wdata_in[`TCBD_BK_POL];
          break_input_on_r <= reg_wdata_in[`TCBD_BK_EN];
          dtg_r  <= reg_wdata_in[`TCBD_BK_DT_HI:`TCBD_BK_DT_LO];
        end
        if (!lck_ge2) begin
          run_offstate_select_r <= reg_wdata_in[`TCBD_BK_RUN_OFFSTATE_SELECT];
          idle_offstate_select_r <= reg_wdata_in[`TCBD_BK_IDLE_OFFSTATE_SELECT];
        end
        if (!lck_written_r) begin
          lck_r         <= reg_wdata_in[`TCBD_BK_LCK_HI:`TCBD_BK_LCK_LO];
          lck_written_r <= 1'b1;
        end
      end
      // Break clears main enable with priority over every set
      if (brk_active) begin
        moe_r <= 1'b0;
      end else if (bk_hit && reg_wdata_in[`TCBD_BK_MOE]) begin
        moe_r <= 1'b1;
      end else if (update_evt_in && aoe_r) begin
        moe_r <= 1'b1;
      end else if (bk_hit) begin
        moe_r <= 1'b0;
      end
    end
  end

  // Polarity and enable act one bus clock after the write
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bkp_eff_r  <= 1'b0;
      break_input_on_eff_r <= 1'b0;
    end else begin
      bkp_eff_r  <= bkp_r;
      break_input_on_eff_r <= break_input_on_r;
    end
  end

  // Main enable, lock permissions and dead time outputs
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      main_output_on_out     <= 1'b0;
      idle_level_wr_ok_out   <= 1'b1;
      polarity_wr_ok_out     <= 1'b1;
      compare_mode_wr_ok_out <= 1'b1;
      dead_time_ticks_out    <= `TCBD_DT_NONE;
    end else begin
      main_output_on_out     <= moe_r && !brk_active;
      idle_level_wr_ok_out   <= !lck_ge1;
      polarity_wr_ok_out     <= !lck_ge2;
      compare_mode_wr_ok_out <= !lck_ge3;
      dead_time_ticks_out    <= tcbd_dt_decode(dtg_r);
    end
  end

  // ------------------------------------------------------------------
  // DMA burst control and window
  // ------------------------------------------------------------------
  wire dc_hit = wr_dctrl || (win_acc && reg_wr_in && win_addr == `TCBD_OFS_DCTRL);

  // Burst state: request held until the last window access
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dbl_r       <= 5'h00;
      dba_r       <= 5'h00;
      burst_cnt_r <= 5'h00;
      dma_req_out <= 1'b0;
    end else begin
      if (dc_hit) begin
        dbl_r       <= reg_wdata_in[`TCBD_DC_LEN_HI:`TCBD_DC_LEN_LO];
        dba_r       <= reg_wdata_in[`TCBD_DC_IDX_HI:`TCBD_DC_IDX_LO];
        burst_cnt_r <= 5'h00;
      end else if (win_acc) begin
        if (burst_last) begin
          burst_cnt_r <= 5'h00;
        end else begin
          burst_cnt_r <= burst_cnt_r + 5'h01;
        end
      end
      // A new event wins over the last access of the previous burst
      if (dma_evt_in) begin
        dma_req_out <= 1'b1;
      end else if (win_acc && burst_last) begin
        dma_req_out <= 1'b0;
      end
    end
  end

  // Forwarding of window accesses to registers outside this block
  wire fwd_ext = (win_addr != `TCBD_OFS_CMP3) && (win_addr != `TCBD_OFS_CMP4) &&
                 (win_addr != `TCBD_OFS_BKDT) && (win_addr != `TCBD_OFS_DCTRL);
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fwd_addr_out  <= 7'h00;
      fwd_wr_out    <= 1'b0;
      fwd_rd_out    <= 1'b0;
      fwd_wdata_out <= `TCBD_RST16;
      fwd_pend_r    <= 1'b0;
    end else begin
      fwd_wr_out <= win_acc && reg_wr_in && fwd_ext;
      fwd_rd_out <= win_acc && reg_rd_in && fwd_ext;
      fwd_pend_r <= win_acc && reg_rd_in && fwd_ext;
      if (win_acc) begin
        fwd_addr_out  <= win_addr;
        fwd_wdata_out <= reg_wdata_in;
      end
    end
  end

  // ------------------------------------------------------------------
  // Read data, one cycle after the strobe, two for forwarded window reads
  // ------------------------------------------------------------------
  reg  [15:0] rd_local;
  reg  [6:0]  rd_addr;
  always @* begin
    rd_addr  = win_acc ? win_addr : reg_addr_in;
    rd_local = `TCBD_RST16;
    case (rd_addr)
      `TCBD_OFS_CMP3:  rd_local = cmp_pre_r[0];
      `TCBD_OFS_CMP4:  rd_local = cmp_pre_r[1];
      `TCBD_OFS_BKDT:  rd_local = {moe_r, aoe_r, bkp_r, break_input_on_r, run_offstate_select_r, idle_offstate_select_r, lck_r, dtg_r};
      `TCBD_OFS_DCTRL: rd_local = {3'h0, dbl_r, 3'h0, dba_r};
      default:         rd_local = `TCBD_RST16;
    endcase
  end

  // Forwarded reads return the outside data one cycle later
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= `TCBD_RST16;
    end else if (fwd_pend_r) begin
      reg_rdata_out <= fwd_rdata_in;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rd_local;
    end
  end

endmodule

// ==== inc/tcbd_defines.vh ====
// Register offsets, field positions and constants of the compare/break/DMA block
`ifndef TCBD_DEFINES_VH
`define TCBD_DEFINES_VH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define TCBD_OFS_CTRL1     7'h00
`define TCBD_OFS_CMP3      7'h3c
`define TCBD_OFS_CMP4      7'h40
`define TCBD_OFS_BKDT      7'h44
`define TCBD_OFS_DCTRL     7'h48
`define TCBD_OFS_WINDOW    7'h4c

// ------------------------------------------------------------------
// Break and dead-time field positions
// ------------------------------------------------------------------
`define TCBD_BK_MOE        15
`define TCBD_BK_AOE        14
`define TCBD_BK_POL        13
`define TCBD_BK_EN         12
`define TCBD_BK_RUN_OFFSTATE_SELECT       11
`define TCBD_BK_IDLE_OFFSTATE_SELECT       10
`define TCBD_BK_LCK_HI     9
`define TCBD_BK_LCK_LO     8
`define TCBD_BK_DT_HI      7
`define TCBD_BK_DT_LO      0

// ------------------------------------------------------------------
// DMA control field positions and masks
// ------------------------------------------------------------------
`define TCBD_DC_LEN_HI     12
`define TCBD_DC_LEN_LO     8
`define TCBD_DC_IDX_HI     4
`define TCBD_DC_IDX_LO     0
`define TCBD_DC_MASK       16'h1f1f

// ------------------------------------------------------------------
// Lock levels and reset values
// ------------------------------------------------------------------
`define TCBD_LCK_NONE      2'h0
`define TCBD_LCK_L1        2'h1
`define TCBD_LCK_L2        2'h2
`define TCBD_LCK_L3        2'h3
`define TCBD_RST16         16'h0000
`define TCBD_DT_NONE       11'h000

// ------------------------------------------------------------------
// Dead-time code decode constants
// ------------------------------------------------------------------
`define TCBD_DT_BASE64     11'h040
`define TCBD_DT_BASE32     11'h020

`endif

// ==== tb/tb.sv ====
// Self-checking bench for the compare/break/DMA block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, upd = 1'b0, devt = 1'b0;
  logic        break_pin = 1'b0, cf = 1'b0, fw, fr, dreq, moe, ok_i, ok_p, ok_c;
  logic [6:0]  addr = 7'h00, fa;
  logic [15:0] wd = 16'h0000, cnt = 16'h0000, rdata, fwd_wd, fwd_rdat;
  logic [1:0]  isin = 2'h0, cap = 2'h0, pre = 2'h0, oen = 2'h0, con = 2'h0, cmatch, oe, coe;
  logic [10:0] dt;
  logic [7:0]  dt_code [4] = '{8'h45, 8'ha3, 8'hc5, 8'hff};
  logic [10:0] dt_exp [4] = '{11'h045, 11'h0c6, 11'h128, 11'h3f0};
  logic [2:0]  ok_exp [4] = '{3'h7, 3'h3, 3'h1, 3'h0};
  logic [15:0] lk_exp [4] = '{16'h0, 16'h0d45, 16'h0245, 16'h0345};
  int          failures = 0;
  int          checks = 0;

  always #50 clk = ~clk;

  tcbd_core DUT (.core_clk_in(clk), .nrst_in(nrst), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_wdata_in(wd), .reg_rdata_out(rdata), .fwd_addr_out(fa),
    .fwd_wr_out(fw), .fwd_rd_out(fr), .fwd_wdata_out(fwd_wd), .fwd_rdata_in(fwd_rdat),
    .counter_in(cnt), .update_evt_in(upd), .dma_evt_in(devt), .dma_ack_in(1'b0),
    .dma_req_out(dreq), .chan_is_input_in(isin), .capture_evt_in(cap),
    .chan_compare_preload_en_in(pre), .chan_output_on_in(oen), .chan_compl_output_on_in(con),
    .break_pin_in(break_pin), .clock_failure_detector_in(cf), .compare_match_out(cmatch),
    .chan_oe_out(oe), .chan_compl_oe_out(coe), .main_output_on_out(moe),
    .idle_level_wr_ok_out(ok_i), .polarity_wr_ok_out(ok_p), .compare_mode_wr_ok_out(ok_c),
    .dead_time_ticks_out(dt));

  tcbd_fwd_model FWD (.clk_in(clk), .addr_in(fa), .wr_in(fw), .rd_in(fr),
    .wdata_in(fwd_wd), .rdata_out(fwd_rdat));

  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Inputs always move 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr16(input logic [6:0] a, input logic [15:0] d);
    tick(1);
    addr = a;
    wd = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
  endtask
  // Window reads forwarded outside the block answer one cycle later than local ones
  task automatic rd16(input logic [6:0] a, input logic [15:0] exp);
    tick(1);
    addr = a;
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    if (a == 7'h4c) tick(1);
    chk(rdata, exp);
  endtask
  task automatic pulse_upd();
    upd = 1'b1;
    tick(1);
    upd = 1'b0;
    tick(2);
  endtask
  task automatic do_reset();
    nrst = 1'b0;
    tick(2);
    nrst = 1'b1;
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs well under 1000 cycles
  initial begin
    #(3000 * 100);
    failures++;
    tally_and_finish();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    do_reset();
    chk({13'h0, ok_i, ok_p, ok_c}, 16'h7);
    rd16(7'h40, 16'h0000);
    rd16(7'h44, 16'h0000);
    rd16(7'h10, 16'h0000);
    // Lock field written as zero keeps every field open
    for (int i = 0; i < 4; i++) begin
      wr16(7'h44, {8'h00, dt_code[i]});
      tick(2);
      chk({5'h0, dt}, {5'h0, dt_exp[i]});
    end
    oen = 2'h3;
    wr16(7'h44, 16'hf000);
    tick(4);
    chk({13'h0, moe, oe}, 16'h7);
    break_pin = 1'b1;
    tick(5);
    chk({13'h0, moe, oe}, 16'h0);
    rd16(7'h44, 16'h7000);
    break_pin = 1'b0;
    tick(4);
    pulse_upd();
    chk({13'h0, moe, oe}, 16'h7);
    wr16(7'h44, 16'he000);
    break_pin = 1'b1;
    tick(5);
    chk({13'h0, moe, oe}, 16'h7);
    wr16(7'h44, 16'hd000);
    break_pin = 1'b0;
    tick(5);
    chk({15'h0, moe}, 16'h0);
    break_pin = 1'b1;
    wr16(7'h44, 16'h0400);
    tick(3);
    chk({13'h0, moe, oe}, 16'h3);
    wr16(7'h44, 16'h0000);
    tick(3);
    chk({13'h0, moe, oe}, 16'h0);
    // Run off-state: the idle side of channel 3 is enabled at its inactive level
    oen = 2'h1;
    wr16(7'h44, 16'h8800);
    tick(3);
    chk({11'h0, moe, oe, coe}, 16'h15);
    // Clock failure alone breaks once break input is enabled
    wr16(7'h44, 16'h9000);
    cf = 1'b1;
    tick(5);
    chk({11'h0, moe, oe, coe}, 16'h0);
    cf = 1'b0;
    // Direct and preloaded compare values
    cnt = 16'h1234;
    wr16(7'h3c, 16'h1234);
    pre = 2'h2;
    wr16(7'h40, 16'h1234);
    tick(2);
    chk({14'h0, cmatch}, 16'h1);
    pulse_upd();
    chk({14'h0, cmatch}, 16'h3);
    isin = 2'h1;
    wr16(7'h3c, 16'h5555);
    rd16(7'h3c, 16'h1234);
    cnt = 16'h0abc;
    cap = 2'h1;
    tick(1);
    cap = 2'h0;
    rd16(7'h3c, 16'h0abc);
    chk({14'h0, cmatch}, 16'h0);
    // Lock levels one to three, each from a fresh reset
    for (int lv = 1; lv < 4; lv++) begin
      do_reset();
      wr16(7'h44, {6'h0, lv[1:0], 8'h45});
      wr16(7'h44, 16'h0c99);
      tick(1);
      chk({13'h0, ok_i, ok_p, ok_c}, {13'h0, ok_exp[lv]});
      rd16(7'h44, lk_exp[lv]);
    end
    // Two DMA bursts of two accesses from index 0x0d
    isin = 2'h0;
    wr16(7'h48, 16'he10d);
    rd16(7'h48, 16'h010d);
    for (int b = 0; b < 2; b++) begin
      devt = 1'b1;
      tick(1);
      devt = 1'b0;
      tick(1);
      chk({15'h0, dreq}, 16'h1);
      wr16(7'h4c, 16'ha000 | b[0]);
      wr16(7'h4c, 16'hb000 | b[0]);
      tick(1);
      chk({15'h0, dreq}, 16'h0);
      chk(FWD.mem[13], 16'ha000 | b[0]);
      chk(FWD.mem[14], 16'hb000 | b[0]);
    end
    rd16(7'h4c, 16'ha001);
    wr16(7'h48, 16'h000f);
    wr16(7'h4c, 16'h0777);
    rd16(7'h3c, 16'h0777);
    tally_and_finish();
  end
endmodule

bind tcbd_core tcbd_core_asserts CHK (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
  .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .fwd_addr_out(fwd_addr_out),
  .fwd_wr_out(fwd_wr_out), .fwd_rd_out(fwd_rd_out), .fwd_wdata_out(fwd_wdata_out),
  .dma_evt_in(dma_evt_in), .dma_req_out(dma_req_out), .chan_is_input_in(chan_is_input_in),
  .compare_match_out(compare_match_out), .idle_level_wr_ok_out(idle_level_wr_ok_out),
  .polarity_wr_ok_out(polarity_wr_ok_out), .compare_mode_wr_ok_out(compare_mode_wr_ok_out));

// ==== tb/tcbd_core_asserts.sv ====
// Port-level checks for the compare/break/DMA block
module tcbd_core_asserts (
  input wire logic        core_clk_in,
  input wire logic        nrst_in,
  input wire logic [6:0]  reg_addr_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic [6:0]  fwd_addr_out,
  input wire logic        fwd_wr_out,
  input wire logic        fwd_rd_out,
  input wire logic [15:0] fwd_wdata_out,
  input wire logic        dma_evt_in,
  input wire logic        dma_req_out,
  input wire logic [1:0]  chan_is_input_in,
  input wire logic [1:0]  compare_match_out,
  input wire logic        idle_level_wr_ok_out,
  input wire logic        polarity_wr_ok_out,
  input wire logic        compare_mode_wr_ok_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  // Access steps used below
  sequence s_dma_start;
    dma_evt_in && !dma_req_out;
  endsequence
  sequence s_rd_unmapped;
    reg_rd_in && !(reg_addr_in inside {7'h3c, 7'h40, 7'h44, 7'h48, 7'h4c});
  endsequence
  sequence s_rd_dctrl;
    reg_rd_in && reg_addr_in == 7'h48;
  endsequence
  a_fwd_wr_cause: assert property (fwd_wr_out |-> $past(reg_wr_in) && $past(reg_addr_in) == 7'h4c)
    else $error("forwarded write without window write");
  a_fwd_rd_cause: assert property (fwd_rd_out |-> $past(reg_rd_in) && $past(reg_addr_in) == 7'h4c)
    else $error("forwarded read without window read");
  a_fwd_wr_data: assert property (fwd_wr_out |-> fwd_wdata_out == $past(reg_wdata_in))
    else $error("forwarded write data differs");
  a_fwd_addr_ok: assert property ((fwd_wr_out || fwd_rd_out) |-> fwd_addr_out[1:0] == 2'h0 &&
    !(fwd_addr_out inside {7'h3c, 7'h40, 7'h44, 7'h48}))
    else $error("forwarded address misaligned or local");
  a_dma_req_rise: assert property (s_dma_start |=> dma_req_out)
    else $error("dma request did not rise");
  a_unmapped_zero: assert property (s_rd_unmapped |=> reg_rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  a_dctrl_resv: assert property (s_rd_dctrl |=> (reg_rdata_out & 16'he0e0) == 16'h0000)
    else $error("reserved control bits read nonzero");
  a_lock_nest_hi: assert property (!compare_mode_wr_ok_out |-> !polarity_wr_ok_out)
    else $error("lock level three without level two");
  a_lock_nest_lo: assert property (!polarity_wr_ok_out |-> !idle_level_wr_ok_out)
    else $error("lock level two without level one");
  a_match_output: assert property (compare_match_out[0] |-> !$past(chan_is_input_in[0]))
    else $error("compare match in input mode");
endmodule

// ==== tb/tcbd_fwd_model.sv ====
// Stand-in for the timer registers reached through the burst window
module tcbd_fwd_model (
  input  wire logic        clk_in,
  input  wire logic [6:0]  addr_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  input  wire logic [15:0] wdata_in,
  output logic      [15:0] rdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:31];
  // Read data answers in the strobe cycle, since the block samples it at the
  // edge that ends that cycle; the inverse otherwise so stale data never matches
  assign rdata_out = rd_in ? mem[addr_in[6:2]] : ~mem[addr_in[6:2]];
  // Writes land at the edge that samples the strobe
  always @(posedge clk_in) begin
    if (wr_in) begin
      mem[addr_in[6:2]] <= wdata_in;
    end
  end
endmodule
